// ---- core/epbc_bridge.sv ----
// Enhanced PWM output stage: bridge steering, dead band and auto-shutdown
//
// Functional notes
// - Full-bridge direction bit change applies from the following PWM cycle.
// - Four counts before period end, B and D go inactive, A and C swap.
// - No dead band in either full-bridge direction.
// - Shutdown sources: low fault input, high comparator one output, per select.
// - Shutdown flag reads 0 in normal run, 1 while outputs are shut down; it reads 0 while outputs wait for the next period start.
// - Shutdown sets the flag; held until firmware or auto-restart clears it.
// - Each enabled pair is forced asynchronously to its shutdown state.
// - Shutdown is level sensitive and persists while the source is asserted.
// - Flag writes are ignored while a shutdown condition is present.
// - After restart, output resumes only at the next period start.
// - Software can set the flag; auto-restart clears it at once.
// - With auto-restart, flag holds during condition and clears after.
// - Half-bridge delays inactive-to-active edges by the dead band.
// - Dead band equals seven low bits, in instruction cycles.
// - Single output mode routes the modulated signal to each enabled pin.
// - In steering, mode low bits choose pin polarity.
// - Steering shutdown affects only steered pins.
// - Steer sync 0 applies at once; 1 applies at next period.
// - Dead band longer than duty keeps the output inactive all cycle.
// - Config 00 single, 01 forward, 10 half, 11 reverse.
`timescale 1ns/1ps
`default_nettype none

`include "epbc_map.svh"

module epbc_bridge #(
	parameter int DB_W  = `EPBC_DB_WIDTH,
	parameter int TMR_W = 8
) (
	input  wire logic                        clk_sys_i,
	input  wire logic                        resetn_i,
	// Time base from the separate timer
	input  wire logic [TMR_W-1:0]            timer_count_i,
	input  wire logic [TMR_W-1:0]            timer_period_i,
	input  wire logic                        period_start_i,
	input  wire logic                        pwm_raw_i,
	// Configuration
	input  wire epbc_pkg::epbc_mode_t        mode_i,
	input  wire epbc_pkg::epbc_shutdown_cfg_t sd_cfg_i,
	input  wire epbc_pkg::epbc_steer_t       steer_i,
	input  wire logic [DB_W-1:0]             deadband_i,
	input  wire logic                        auto_restart_enable_i,
	// Shutdown sources and flag access
	input  wire logic                        fault_input_n_i,
	input  wire logic                        comparator_one_output_i,
	input  wire logic                        flag_wr_i,
	input  wire logic                        flag_wdata_i,
	output logic                             shutdown_event_flag_o,
	output epbc_pkg::epbc_pins_t             pins_o
);

	if (DB_W != `EPBC_DB_WIDTH) $error("epbc_bridge: dead band must be seven bits");
	if (TMR_W < 3 || TMR_W > 16) $error("epbc_bridge: TMR_W out of range");

	default clocking cb_sys @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	logic       pwm_on;
	logic [1:0] cfg;
	logic       pol_ac_low;
	logic       pol_bd_low;

	assign pwm_on     = (mode_i.ccp_mode_field[3:2] == `EPBC_MODE_PWM);
	assign cfg        = mode_i.output_config_field;
	assign pol_ac_low = mode_i.ccp_mode_field[1];
	assign pol_bd_low = mode_i.ccp_mode_field[0];

	// ------------------------------------------------------------
	// Shutdown detection and flag
	// ------------------------------------------------------------
	logic cond;
	logic flag;
	logic next_flag;
	logic run_gate;
	logic next_run_gate;

	// Combinational, so pins react without waiting for a clock edge
	assign cond = (sd_cfg_i.shutdown_source_sel[`EPBC_SRC_FAULT_BIT] && !fault_input_n_i)
		|| (sd_cfg_i.shutdown_source_sel[`EPBC_SRC_CMP_BIT] && comparator_one_output_i);

	always_comb begin
		next_flag = flag;
		if (auto_restart_enable_i && !cond) begin
			next_flag = 1'b0;
		end
		if (flag_wr_i && !cond) begin
			next_flag = flag_wdata_i;
		end
		if (cond) begin
			next_flag = 1'b1;
		end
		// Output gate reopens only on a period boundary once the flag is clear
		next_run_gate = run_gate;
		if (flag || cond) begin
			next_run_gate = 1'b0;
		end else if (period_start_i) begin
			next_run_gate = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flag     <= 1'b0;
			run_gate <= 1'b0;
		end else begin
			flag     <= next_flag;
			run_gate <= next_run_gate;
		end
	end

	logic shut;
	assign shut                  = cond || flag || !run_gate;
	assign shutdown_event_flag_o = flag || cond;

	// ------------------------------------------------------------
	// Full-bridge direction sequencing
	// ------------------------------------------------------------
	epbc_pkg::epbc_fb_state_t fb_state;
	epbc_pkg::epbc_fb_state_t next_fb_state;
	logic                     dir_rev;
	logic                     next_dir_rev;
	logic                     near_end;
	logic                     want_rev;

	function automatic logic is_full_bridge(input logic [1:0] c);
		is_full_bridge = (c == `EPBC_CFG_FB_FWD) || (c == `EPBC_CFG_FB_REV);
	endfunction

	assign want_rev = (cfg == `EPBC_CFG_FB_REV);
	assign near_end = (timer_period_i >= TMR_W'(`EPBC_DIR_LEAD_COUNTS))
		&& (timer_count_i == timer_period_i - TMR_W'(`EPBC_DIR_LEAD_COUNTS));

	always_comb begin
		next_fb_state = fb_state;
		next_dir_rev  = dir_rev;
		case (fb_state)
			epbc_pkg::EPBC_FB_RUN: begin
				if (is_full_bridge(cfg) && want_rev != dir_rev) begin
					next_fb_state = epbc_pkg::EPBC_FB_PEND;
				end
			end
			epbc_pkg::EPBC_FB_PEND: begin
				if (!is_full_bridge(cfg) || want_rev == dir_rev) begin
					next_fb_state = epbc_pkg::EPBC_FB_RUN;
				end else if (near_end) begin
					next_dir_rev  = want_rev;
					next_fb_state = epbc_pkg::EPBC_FB_BLANK;
				end
			end
			epbc_pkg::EPBC_FB_BLANK: begin
				if (period_start_i) begin
					next_fb_state = epbc_pkg::EPBC_FB_RUN;
				end
			end
			default: begin
				next_fb_state = epbc_pkg::EPBC_FB_RUN;
			end
		endcase
		// Outside full-bridge the direction simply follows the config
		if (!is_full_bridge(cfg)) begin
			next_dir_rev = want_rev;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fb_state <= epbc_pkg::EPBC_FB_RUN;
			dir_rev  <= 1'b0;
		end else begin
			fb_state <= next_fb_state;
			dir_rev  <= next_dir_rev;
		end
	end

	// ------------------------------------------------------------
	// Steering register with optional period sync
	// ------------------------------------------------------------
	logic [3:0] steer_q;
	logic [3:0] next_steer_q;
	logic [3:0] steer_eff;

	always_comb begin
		next_steer_q = steer_q;
		if (!steer_i.steer_sync_select || period_start_i) begin
			next_steer_q = steer_i.steer_enable_bits;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			steer_q <= '0;
		end else begin
			steer_q <= next_steer_q;
		end
	end

	// Sync 0 takes the written value in the same cycle
	assign steer_eff = steer_i.steer_sync_select ? steer_q : steer_i.steer_enable_bits;

	// ------------------------------------------------------------
	// Half-bridge dead band, rising edges only
	// ------------------------------------------------------------
	logic half;
	logic db_a;
	logic db_b;

	assign half = (cfg == `EPBC_CFG_HALF);

	epbc_deadband #(
		.DB_W(DB_W)
	) u_db_a (
		.clk_sys_i     (clk_sys_i),
		.resetn_i      (resetn_i),
		.period_start_i(period_start_i),
		.active_i      (pwm_raw_i),
		.delay_i       (deadband_i),
		.active_o      (db_a)
	);

	epbc_deadband #(
		.DB_W(DB_W)
	) u_db_b (
		.clk_sys_i     (clk_sys_i),
		.resetn_i      (resetn_i),
		.period_start_i(period_start_i),
		.active_i      (!pwm_raw_i),
		.delay_i       (deadband_i),
		.active_o      (db_b)
	);

	// ------------------------------------------------------------
	// Output routing (active-high view, pins d c b a)
	// ------------------------------------------------------------
	logic [3:0] act;
	logic [3:0] used;
	logic [3:0] level_q;
	logic [3:0] next_level_q;
	logic       blank;

	assign blank = (fb_state == epbc_pkg::EPBC_FB_BLANK) && !period_start_i;

	always_comb begin
		act  = 4'h0;
		used = 4'h0;
		case (cfg)
			`EPBC_CFG_SINGLE: begin
				act  = steer_eff & {4{pwm_raw_i}};
				used = steer_eff;
			end
			`EPBC_CFG_HALF: begin
				act  = {2'b00, db_b, db_a};
				used = 4'h3;
			end
			`EPBC_CFG_FB_FWD,
			`EPBC_CFG_FB_REV: begin
				// Uses the latched direction, never dead band
				used = 4'hf;
				if (dir_rev) begin
					act = {1'b0, 1'b1, pwm_raw_i && !blank, 1'b0};
				end else begin
					act = {pwm_raw_i && !blank, 1'b0, 1'b0, 1'b1};
				end
			end
			default: begin
				act  = 4'h0;
				used = 4'h0;
			end
		endcase
		if (!pwm_on) begin
			used = 4'h0;
		end
		next_level_q = act ^ {pol_bd_low, pol_ac_low, pol_bd_low, pol_ac_low};
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level_q <= 4'h0;
		end else begin
			level_q <= next_level_q;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers with combinational shutdown override
	// ------------------------------------------------------------
	function automatic logic [1:0] sd_pin(input logic [1:0] pss);
		// Bit 1 is the level, bit 0 is the output enable (low drives)
		case (pss)
			`EPBC_PSS_LOW:  sd_pin = 2'b00;
			`EPBC_PSS_HIGH: sd_pin = 2'b10;
			default:        sd_pin = 2'b01;
		endcase
	endfunction

	logic [1:0] sd_ac;
	logic [1:0] sd_bd;

	assign sd_ac = sd_pin(sd_cfg_i.pair_ac_shutdown_state);
	assign sd_bd = sd_pin(sd_cfg_i.pair_bd_shutdown_state);

	always_comb begin
		pins_o.level = level_q;
		pins_o.oe_n  = ~used;
		if (shut) begin
			// Only enabled pins are forced; others stay released
			pins_o.level = (level_q & ~used) | (used & {sd_bd[1], sd_ac[1], sd_bd[1], sd_ac[1]});
			pins_o.oe_n  = ~used | (used & {sd_bd[0], sd_ac[0], sd_bd[0], sd_ac[0]});
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_dir_change;
		fb_state == epbc_pkg::EPBC_FB_PEND && near_end && is_full_bridge(cfg) && want_rev != dir_rev;
	endsequence

	chk_flag_on_cond: assert property (cond |=> flag)
		else $error("flag not set by shutdown condition");

	chk_flag_out: assert property (cond |-> shutdown_event_flag_o)
		else $error("flag output low during condition");

	chk_write_ignored: assert property ((flag && cond && flag_wr_i && !flag_wdata_i)
		|=> flag) else $error("flag cleared during condition");

	chk_auto_clear: assert property ((auto_restart_enable_i && !cond && !flag_wr_i)
		|=> !flag) else $error("auto restart did not clear flag");

	chk_sw_shutdown: assert property ((flag_wr_i && flag_wdata_i && !cond)
		|=> (flag && shut)) else $error("software shutdown not entered");

	chk_restart_period: assert property ((!run_gate && !period_start_i) |=> !run_gate)
		else $error("output resumed mid period");

	chk_shut_pins: assert property ((cond && used[0]
		&& sd_cfg_i.pair_ac_shutdown_state == `EPBC_PSS_LOW)
		|-> (!pins_o.level[0] && !pins_o.oe_n[0])) else $error("pin a not forced low");

	chk_dir_blank: assert property (s_dir_change |=> (blank && dir_rev == $past(want_rev)))
		else $error("direction swap missed");

	chk_dir_hold: assert property ((is_full_bridge(cfg) && is_full_bridge($past(cfg))
		&& fb_state != epbc_pkg::EPBC_FB_PEND && !$past(near_end)) |-> $stable(dir_rev))
		else $error("direction changed early");

	chk_steer_sync: assert property ((steer_i.steer_sync_select && !period_start_i)
		|=> $stable(steer_q)) else $error("steer moved mid period");

	chk_steer_only: assert property ((cfg == `EPBC_CFG_SINGLE && !steer_eff[2])
		|-> pins_o.oe_n[2]) else $error("unsteered pin driven");

endmodule

`default_nettype wire

// ---- core/epbc_deadband.sv ----
// Rising-edge delay for one half-bridge output
`timescale 1ns/1ps
`default_nettype none

`include "epbc_map.svh"

module epbc_deadband #(
	parameter int DB_W = `EPBC_DB_WIDTH
) (
	input  wire logic            clk_sys_i,
	input  wire logic            resetn_i,
	input  wire logic            period_start_i,
	input  wire logic            active_i,
	input  wire logic [DB_W-1:0] delay_i,
	output logic                 active_o
);

	if (DB_W < 1 || DB_W > 16) $error("epbc_deadband: DB_W out of range");

	logic [DB_W-1:0] cnt;
	logic            out_q;
	logic [DB_W-1:0] next_cnt;
	logic            next_out_q;

	// Going inactive is immediate; going active waits delay_i cycles of
	// steady activity. If the active phase ends first the output stays low.
	always_comb begin
		next_cnt   = cnt;
		next_out_q = out_q;
		if (!active_i || period_start_i) begin
			next_cnt   = '0;
			next_out_q = 1'b0;
		end
		if (active_i) begin
			if (cnt >= delay_i) begin
				next_out_q = 1'b1;
			end else begin
				next_cnt = cnt + DB_W'(1);
			end
			// The start cycle is the first delay cycle, as for a mid-period edge
			if (period_start_i) begin
				next_cnt   = DB_W'(1);
				next_out_q = (delay_i == '0);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt   <= '0;
			out_q <= 1'b0;
		end else begin
			cnt   <= next_cnt;
			out_q <= next_out_q;
		end
	end

	assign active_o = out_q;

endmodule

`default_nettype wire

// ---- core/epbc_map.svh ----
// Constant map for the enhanced PWM bridge output stage
`ifndef EPBC_MAP_SVH
`define EPBC_MAP_SVH

`define EPBC_CFG_SINGLE      2'h0
`define EPBC_CFG_FB_FWD      2'h1
`define EPBC_CFG_HALF        2'h2
`define EPBC_CFG_FB_REV      2'h3
`define EPBC_MODE_PWM        2'h3
`define EPBC_SRC_FAULT_BIT   0
`define EPBC_SRC_CMP_BIT     1
`define EPBC_PSS_LOW         2'h0
`define EPBC_PSS_HIGH        2'h1
`define EPBC_DIR_LEAD_COUNTS 8'h04
`define EPBC_DB_WIDTH        7

`endif

// ---- core/epbc_pkg.sv ----
// Types shared by the enhanced PWM bridge output stage
package epbc_pkg;

	typedef struct packed {
		logic [1:0] output_config_field;
		logic [3:0] ccp_mode_field;
	} epbc_mode_t;

	typedef struct packed {
		logic [2:0] shutdown_source_sel;
		logic [1:0] pair_ac_shutdown_state;
		logic [1:0] pair_bd_shutdown_state;
	} epbc_shutdown_cfg_t;

	typedef struct packed {
		logic [3:0] steer_enable_bits;
		logic       steer_sync_select;
	} epbc_steer_t;

	// Pins ordered d, c, b, a from msb
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe_n;
	} epbc_pins_t;

	typedef enum logic [1:0] {
		EPBC_FB_RUN   = 2'b00,
		EPBC_FB_PEND  = 2'b01,
		EPBC_FB_BLANK = 2'b10
	} epbc_fb_state_t;

endpackage

// ---- sim/epbc_drv_model.sv ----
// Behavioural model of the external bridge switch drivers
`timescale 1ns/1ps
`default_nettype none

module epbc_drv_model (
	input  wire epbc_pkg::epbc_pins_t pins_i,
	output logic [3:0]                pin_lvl_o
);

	// ----------------------------------------
	// Pin resolution
	// ----------------------------------------
	// Released pins fall to the board pull-down so the switches stay off
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_lvl_o[i] = pins_i.oe_n[i] ? 1'b0 : pins_i.level[i];
		end
	end

endmodule

`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the enhanced PWM bridge output stage
`timescale 1ns/1ps
`default_nettype none

`include "epbc_map.svh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;

	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic                          clk_sys_i = 1'b0;
	logic                          resetn_i  = 1'b0;
	logic [7:0]                    cnt       = 8'h00;
	logic [7:0]                    per       = 8'h13;
	logic [7:0]                    duty      = 8'h0a;
	epbc_pkg::epbc_mode_t          mode      = '{2'h0, 4'hc};
	epbc_pkg::epbc_shutdown_cfg_t  sd        = '{3'h1, 2'h1, 2'h0};
	epbc_pkg::epbc_steer_t         st        = '{4'hf, 1'b0};
	logic [6:0]                    dbv       = 7'h00;
	logic                          are       = 1'b0;
	logic                          flt_n     = 1'b1;
	logic                          cmp       = 1'b0;
	logic                          fwr       = 1'b0;
	logic                          fwd       = 1'b0;
	logic                          flag;
	epbc_pkg::epbc_pins_t          pins;
	logic [3:0]                    lvl;
	logic                          pstart;
	logic                          raw;
	int                            n_fail    = 0;
	int                            checked   = 0;

	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	// Timer stand-in: counts 0..per, inputs move on the falling edge
	always @(negedge clk_sys_i) cnt <= (cnt == per) ? 8'h00 : cnt + 8'h01;
	assign pstart = (cnt == 8'h00);
	assign raw    = (cnt < duty);

	epbc_bridge i_dut (
		.clk_sys_i               (clk_sys_i),
		.resetn_i                (resetn_i),
		.timer_count_i           (cnt),
		.timer_period_i          (per),
		.period_start_i          (pstart),
		.pwm_raw_i               (raw),
		.mode_i                  (mode),
		.sd_cfg_i                (sd),
		.steer_i                 (st),
		.deadband_i              (dbv),
		.auto_restart_enable_i   (are),
		.fault_input_n_i         (flt_n),
		.comparator_one_output_i (cmp),
		.flag_wr_i               (fwr),
		.flag_wdata_i            (fwd),
		.shutdown_event_flag_o   (flag),
		.pins_o                  (pins)
	);

	epbc_drv_model i_drv (
		.pins_i    (pins),
		.pin_lvl_o (lvl)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Bounded wait for a timer count, one falling edge at least
	task automatic at(input logic [7:0] n);
		int k;
		k = 0;
		do begin
			@(negedge clk_sys_i);
			#1;
			k++;
		end while (cnt !== n && k < 200);
		if (cnt !== n) begin
			n_fail++;
			complete_run();
		end
	endtask

	task automatic flag_write(input logic v);
		fwr = 1'b1;
		fwd = v;
		@(negedge clk_sys_i);
		#1;
		fwr = 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_steer();
		at(8'h03);
		`CHK(pins, {4'hf, 4'h0})
		mode = '{`EPBC_CFG_SINGLE, 4'hf};
		at(8'h05);
		`CHK(pins.level, 4'h0)
		mode = '{`EPBC_CFG_SINGLE, 4'hc};
		st = '{4'h3, 1'b1};
		at(8'h07);
		`CHK(pins.oe_n, 4'h0)
		at(8'h02);
		`CHK(pins.oe_n, 4'hc)
		st = '{4'h1, 1'b0};
		at(8'h04);
		`CHK(pins.oe_n, 4'he)
		st = '{4'h3, 1'b0};
	endtask

	task automatic sc_fault_fw();
		cmp = 1'b1;
		at(8'h05);
		`CHK(flag, 1'b0)
		cmp = 1'b0;
		flt_n = 1'b0;
		#1;
		`CHK(pins, {4'h1, 4'hc})
		`CHK(flag, 1'b1)
		@(negedge clk_sys_i);
		#1;
		flag_write(1'b0);
		flt_n = 1'b1;
		at(8'h08);
		`CHK(flag, 1'b1)
		flag_write(1'b0);
		@(negedge clk_sys_i);
		#1;
		`CHK(flag, 1'b0)
		`CHK(pins.level[1:0], 2'b01)
		at(8'h02);
		`CHK(pins.level[1:0], 2'b11)
	endtask

	task automatic sc_auto();
		sd = '{3'h2, 2'h0, 2'h2};
		are = 1'b1;
		at(8'h04);
		cmp = 1'b1;
		#1;
		`CHK(pins.oe_n[1], 1'b1)
		`CHK(lvl[1:0], 2'b00)
		repeat (3) @(negedge clk_sys_i);
		#1;
		`CHK(flag, 1'b1)
		cmp = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		#1;
		`CHK(flag, 1'b0)
		flag_write(1'b1);
		`CHK(flag, 1'b1)
		`CHK(pins.oe_n, 4'he)
		repeat (2) @(negedge clk_sys_i);
		#1;
		`CHK(flag, 1'b0)
		at(8'h02);
		`CHK(pins, {4'h3, 4'hc})
		are = 1'b0;
	endtask

	// Rise and fall position of output A over one period
	task automatic meas(input logic [6:0] d, output int r, output int f);
		r = -1;
		f = -1;
		dbv = d;
		at(8'h13);
		repeat (20) begin
			@(negedge clk_sys_i);
			#1;
			if (pins.level[0] === 1'b1 && r < 0) r = cnt;
			if (pins.level[0] === 1'b0 && r >= 0 && f < 0) f = cnt;
		end
	endtask

	task automatic sc_half();
		int r0, f0, r1, f1, r2, f2;
		mode = '{`EPBC_CFG_HALF, 4'hc};
		duty = 8'h08;
		meas(7'h00, r0, f0);
		meas(7'h04, r1, f1);
		meas(7'h0c, r2, f2);
		`CHK(r1, r0 + 4)
		`CHK(f1, f0)
		`CHK(r2, -1)
		`CHK(pins.oe_n, 4'hc)
	endtask

	task automatic sc_full();
		mode = '{`EPBC_CFG_FB_FWD, 4'hc};
		dbv = 7'h05;
		duty = 8'h12;
		at(8'h01);
		at(8'h01);
		`CHK(pins, {4'h9, 4'h0})
		duty = 8'h08;
		at(8'h05);
		mode = '{`EPBC_CFG_FB_REV, 4'hc};
		at(8'h08);
		`CHK(pins.level, 4'h9)
		at(8'h11);
		`CHK(pins.level, 4'h4)
		at(8'h02);
		`CHK(pins.level, 4'h6)
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge clk_sys_i);
		`CHK(flag, 1'b0)
		resetn_i = 1'b1;
		at(8'h01);
		`CHK(flag, 1'b0)
		sc_steer();
		sc_fault_fw();
		sc_auto();
		sc_half();
		sc_full();
		complete_run();
	end

endmodule

`default_nettype wire
